// *** design/hotplug_fault_status_logic.sv ***
// Slot B fault indication and common status register
`timescale 1ns/1ps
module hotplug_fault_status_logic (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire hp_fault_pkg::reg_req_t  req,
  input  wire hp_fault_pkg::fault_evt_t evt,
  input  wire logic                    slot_b_main_on_in,
  input  wire logic                    slot_b_aux_enable_in,
  input  wire logic                    slot_b_force_on_n_in,
  input  wire logic                    slot_b_gp_input,
  input  wire logic                    slot_a_gp_input,
  input  wire logic                    serial_power_control,
  input  wire logic                    main_enable_bit,
  output logic [7:0]                   rdata,
  output logic                         slot_b_fault_n_out,
  output logic                         slot_b_fault_n_oe,
  output logic                         int_n
);
  //------------------------------------------------------------------
  // Input synchronisers
  //------------------------------------------------------------------
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic       on_s;
  logic       aux_s;
  logic       force_n_s;
  logic       gpb_s;
  logic       gpa_s;

  // Pins are asynchronous; two flops before use
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= 5'h1c;
      sync_r <= 5'h1c;
    end else begin
      meta_r <= {slot_b_force_on_n_in, slot_b_gp_input, slot_a_gp_input,
                 slot_b_main_on_in, slot_b_aux_enable_in};
      sync_r <= meta_r;
    end
  end
  assign {force_n_s, gpb_s, gpa_s, on_s, aux_s} = sync_r;

  //------------------------------------------------------------------
  // Slot B fault latch
  //------------------------------------------------------------------
  logic main_fault_r;
  logic main_fault_nxt;
  logic aux_fault_r;
  logic aux_fault_nxt;
  logic fault_active;

  // Each cause holds until its own enable drops; with both latched, both must drop
  assign main_fault_nxt = serial_power_control ? 1'b0 :
                          (evt.main12_oc | evt.main3_oc) ? 1'b1 :
                          (main_fault_r & on_s); // RULE1 RULE3 RULE4
  assign aux_fault_nxt  = serial_power_control ? 1'b0 :
                          evt.aux_oc ? 1'b1 :
                          (aux_fault_r & aux_s); // RULE2 RULE3 RULE4
  assign fault_active   = main_fault_r | aux_fault_r; // RULE16 RULE7

  always_ff @(posedge clk) begin
    if (srst) begin
      main_fault_r <= 1'b0;
      aux_fault_r  <= 1'b0;
    end else begin
      main_fault_r <= main_fault_nxt;
      aux_fault_r  <= aux_fault_nxt;
    end
  end

  //------------------------------------------------------------------
  // Slot B overcurrent status bits, write one to clear
  //------------------------------------------------------------------
  logic       wr_slot_b;
  logic       wr_common;
  logic [2:0] oc_r;
  logic [2:0] oc_evt;
  logic [2:0] oc_clr;
  logic [2:0] oc_nxt;

  assign wr_slot_b = req.wr & (req.addr == hp_fault_pkg::SLOT_B_STATUS_ADDR);
  assign wr_common = req.wr & (req.addr == hp_fault_pkg::COMMON_STATUS_ADDR);
  assign oc_evt = serial_power_control ? 3'h0 :
                  {evt.aux_oc, evt.main12_oc, evt.main3_oc};
  assign oc_clr = wr_slot_b ?
                  {req.wdata[hp_fault_pkg::AUX_OC_BIT],
                   req.wdata[hp_fault_pkg::MAIN12_OC_BIT],
                   req.wdata[hp_fault_pkg::MAIN3_OC_BIT]} : 3'h0;
  // Set beats clear so a fresh event is never lost; fault pin untouched
  // Serial power control empties them, so no stale cause stays visible
  assign oc_nxt = serial_power_control ? 3'h0 :
                  (oc_evt | (oc_r & ~oc_clr)); // RULE15 RULE4

  always_ff @(posedge clk) begin
    if (srst) begin
      oc_r <= 3'h0;
    end else begin
      oc_r <= oc_nxt;
    end
  end

  //------------------------------------------------------------------
  // Common status register
  //------------------------------------------------------------------
  logic mask_r;
  logic uv_r;
  logic uv_nxt;
  logic ot_r;
  logic ot_nxt;
  logic uv_set;

  // Lockout only counts when the slot was meant to be on
  assign uv_set = evt.supply_low_lockout &
                  (on_s | main_enable_bit); // RULE11 RULE12
  assign uv_nxt = uv_set |
                  (uv_r & ~(wr_common & req.wdata[hp_fault_pkg::UV_BIT]));
                  // RULE14
  assign ot_nxt = evt.overtemp |
                  (ot_r & ~(wr_common & req.wdata[hp_fault_pkg::OT_BIT]));
                  // RULE13 RULE14

  always_ff @(posedge clk) begin
    if (srst) begin
      mask_r <= hp_fault_pkg::COMMON_STATUS_RST[hp_fault_pkg::MASK_BIT];
      uv_r   <= hp_fault_pkg::COMMON_STATUS_RST[hp_fault_pkg::UV_BIT];
      ot_r   <= hp_fault_pkg::COMMON_STATUS_RST[hp_fault_pkg::OT_BIT];
    end else begin
      if (wr_common) begin
        mask_r <= req.wdata[hp_fault_pkg::MASK_BIT]; // RULE9
      end
      uv_r <= uv_nxt;
      ot_r <= ot_nxt;
    end
  end

  //------------------------------------------------------------------
  // Read data, pins and interrupt
  //------------------------------------------------------------------
  logic [7:0] common_rd;
  logic [7:0] slot_b_rd;
  logic [7:0] rdata_nxt;
  logic       any_flag;

  // Live GPI levels; reserved bits read zero
  assign common_rd = {2'b00, gpb_s, gpa_s, mask_r, uv_r, ot_r, 1'b0}; // RULE8
  assign slot_b_rd = {fault_active, 2'b00, oc_r[2], 1'b0, oc_r[1], 1'b0,
                      oc_r[0]}; // RULE7 RULE16
  assign rdata_nxt = ~req.rd ? rdata :
                     (req.addr == hp_fault_pkg::COMMON_STATUS_ADDR) ?
                     common_rd :
                     (req.addr == hp_fault_pkg::SLOT_B_STATUS_ADDR) ?
                     slot_b_rd : 8'h00;
  assign any_flag  = uv_r | ot_r | (|oc_r);

  // No alert response logic exists; host polls the status registers
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata              <= 8'h00;
      slot_b_fault_n_out <= 1'b0;
      slot_b_fault_n_oe  <= 1'b0;
      int_n              <= 1'b1;
    end else begin
      rdata              <= rdata_nxt;
      slot_b_fault_n_out <= 1'b0;
      slot_b_fault_n_oe  <= fault_active & force_n_s; // RULE6 RULE4
      int_n              <= ~(any_flag & ~mask_r); // RULE17 RULE9 RULE10
    end
  end
endmodule

// *** design/hp_fault_pkg.sv ***
// Constants and carrier types for the hot-plug fault and common status logic
//------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------
// Summary of operation
// RULE1 - Main overcurrent fault clears only after slot B main-on input goes low
// RULE2 - Aux overcurrent fault clears only after slot B aux-enable goes low
// RULE3 - Both overcurrents need main-on and aux-enable low before clearing
// RULE4 - Serial power control keeps fault status bit and fault pin inactive
// RULE5 - Under serial power control system ties main-on and aux-enable low
// RULE6 - Forced-on input low releases the slot B fault pin unconditionally
// RULE7 - Fault status bit ignores forced-on and reports real fault state
// RULE8 - Common status bits 5 and 4 show live general-purpose input levels
// RULE9 - Interrupt mask bit 3: zero enables interrupt, one suppresses it
// RULE10 - Device never answers the alert response protocol
// RULE11 - Undervoltage flag bit 2 sets on supply-low lockout isolation fault
// RULE12 - Undervoltage flag sets only while main-on asserted or main enable set
// RULE13 - Over-temperature flag bit 1 sets when die exceeds limit
// RULE14 - Temperature and undervoltage flags clear only by writing one
// RULE15 - Writing one clears an overcurrent bit and interrupt, not fault pin
// RULE16 - Fault status bit reads one while the fault pin is driven low
// RULE17 - Interrupt low while any flag set and mask zero
package hp_fault_pkg;
  localparam logic [7:0] COMMON_STATUS_ADDR  = 8'h06;
  localparam logic [7:0] SLOT_B_STATUS_ADDR  = 8'h05;
  localparam logic [7:0] COMMON_STATUS_RST   = 8'h00;
  localparam int         GPI_B_BIT           = 5;
  localparam int         GPI_A_BIT           = 4;
  localparam int         MASK_BIT            = 3;
  localparam int         UV_BIT              = 2;
  localparam int         OT_BIT              = 1;
  localparam int         FAULT_BIT           = 7;
  localparam int         AUX_OC_BIT          = 4;
  localparam int         MAIN12_OC_BIT       = 2;
  localparam int         MAIN3_OC_BIT        = 0;

  // Register access request from the serial bus front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Fault events from the analog monitors
  typedef struct packed {
    logic main12_oc;
    logic main3_oc;
    logic aux_oc;
    logic supply_low_lockout;
    logic overtemp;
  } fault_evt_t;
endpackage

// *** testbench/hotplug_fault_status_properties.sv ***
// Checker for fault pin, interrupt and read-back timing
`timescale 1ns/1ps
module hotplug_fault_status_properties (
  input logic                     clk,
  input logic                     srst,
  input hp_fault_pkg::reg_req_t   req,
  input hp_fault_pkg::fault_evt_t evt,
  input logic                     slot_b_main_on_in,
  input logic                     slot_b_aux_enable_in,
  input logic                     slot_b_force_on_n_in,
  input logic                     slot_b_gp_input,
  input logic                     serial_power_control,
  input logic [7:0]               rdata,
  input logic                     slot_b_fault_n_oe,
  input logic                     int_n
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);
  // Reads of the common and slot B status bytes
  sequence rd_cs; req.rd && req.addr == 8'h06 && !req.wr; endsequence
  sequence rd_sb; req.rd && req.addr == 8'h05; endsequence
  // Slot enabled and free, so a latched fault must stay
  wire on_free = slot_b_main_on_in && slot_b_aux_enable_in
                 && slot_b_force_on_n_in && !serial_power_control;
  force_release_a: assert property ((!slot_b_force_on_n_in)[*4]
    |-> !slot_b_fault_n_oe) else $error("pin driven while forced");
  serial_quiet_a: assert property (serial_power_control[*3]
    |-> !slot_b_fault_n_oe) else $error("pin driven in serial mode");
  fault_hold_a: assert property (
    on_free[*4] ##0 slot_b_fault_n_oe
    |=> slot_b_fault_n_oe) else $error("fault dropped while on");
  int_cause_a: assert property ($fell(int_n)
    |-> $past(evt, 2) != '0 || $past(req.wr, 2))
    else $error("interrupt without cause");
  gpi_live_a: assert property ($stable(slot_b_gp_input)[*4] ##0 rd_cs
    |=> rdata[5] == $past(slot_b_gp_input)) else $error("gpi b stale");
  ot_seen_a: assert property (evt.overtemp ##1 rd_cs
    |=> rdata[1]) else $error("overtemp flag missing");
  ot_kept_a: assert property (rd_cs ##1 (rdata[1] && !req.wr) ##1 rd_cs
    |=> rdata[1]) else $error("overtemp flag lost");
  status_pin_a: assert property (slot_b_force_on_n_in[*4] ##0 rd_sb
    |=> rdata[7] == slot_b_fault_n_oe) else $error("status bit vs pin");
endmodule
bind hotplug_fault_status_logic hotplug_fault_status_properties chk (
  .clk(clk), .srst(srst), .req(req), .evt(evt), .rdata(rdata),
  .slot_b_main_on_in(slot_b_main_on_in), .int_n(int_n),
  .slot_b_aux_enable_in(slot_b_aux_enable_in),
  .slot_b_force_on_n_in(slot_b_force_on_n_in),
  .slot_b_gp_input(slot_b_gp_input),
  .serial_power_control(serial_power_control),
  .slot_b_fault_n_oe(slot_b_fault_n_oe));

// *** testbench/slot_ctrl_model.sv ***
// Slot control logic model driving the slot B enable pins
`timescale 1ns/1ps
module slot_ctrl_model (
  input  logic want_main,
  input  logic want_aux,
  input  logic serial_power_control,
  output logic main_on,
  output logic aux_en
);
  // Pins grounded while the bus owns slot power
  assign main_on = want_main && !serial_power_control;
  assign aux_en  = want_aux && !serial_power_control;
endmodule

// *** testbench/hotplug_fault_status_logic_test.sv ***
// Self-checking bench for the fault and common status logic
`timescale 1ns/1ps
module hotplug_fault_status_logic_test;
  logic                     clk = 0, srst = 1, frc_n = 1, spc = 0, men = 0;
  logic                     wm = 0, wa = 0, on_w, aux_w, fo, oe, int_n;
  logic                     gpb = 1, gpa = 0;
  logic [7:0]               rdata;
  hp_fault_pkg::reg_req_t   req = '0;
  hp_fault_pkg::fault_evt_t evt = '0;
  logic [4:0]               ev [3] = '{5'h08, 5'h04, 5'h14};
  int                       miscompares = 0, num_checks = 0, cycles = 0;
  wire                      pin = oe ? fo : 1'b1; // Pulled up when free
  always #12.5 clk = ~clk;
  slot_ctrl_model partner (.want_main(wm), .want_aux(wa),
    .serial_power_control(spc), .main_on(on_w), .aux_en(aux_w));
  hotplug_fault_status_logic uut (.clk(clk), .srst(srst), .req(req),
    .evt(evt), .slot_b_main_on_in(on_w), .slot_b_aux_enable_in(aux_w),
    .slot_b_force_on_n_in(frc_n), .slot_b_gp_input(gpb),
    .slot_a_gp_input(gpa), .serial_power_control(spc),
    .main_enable_bit(men), .rdata(rdata), .slot_b_fault_n_out(fo),
    .slot_b_fault_n_oe(oe), .int_n(int_n));
  // Hang guard, well past the length of the sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk) #2;
  endtask
  // One access; read data is loaded on the same edge that takes the request
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk) #2 req = '0;
    idle(1);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    cmp("rdata", exp, rdata);
  endtask
  task automatic pulse(hp_fault_pkg::fault_evt_t e);
    evt = e;
    @(posedge clk) #2 evt = '0;
  endtask
  // Flag, mask and fault pin sequences
  initial begin
    idle(10);
    srst = 0;
    // Pin synchronisers still hold reset levels for two edges
    idle(3);
    rd(8'h06, 8'h20);
    pulse(5'h01);
    rd(8'h06, 8'h22);
    rd(8'h06, 8'h22);
    cmp("int_n", 8'h00, {7'h0, int_n});
    acc(1'b1, 8'h06, 8'h02);
    idle(1);
    rd(8'h06, 8'h20);
    cmp("int_n", 8'h01, {7'h0, int_n});
    acc(1'b1, 8'h06, 8'h08);
    pulse(5'h01);
    rd(8'h06, 8'h2a);
    cmp("int_n", 8'h01, {7'h0, int_n});
    acc(1'b1, 8'h06, 8'h02);
    pulse(5'h02);
    rd(8'h06, 8'h20);
    men = 1;
    pulse(5'h02);
    rd(8'h06, 8'h24);
    men = 0;
    acc(1'b1, 8'h06, 8'h04);
    gpb = 0;
    gpa = 1;
    idle(3);
    rd(8'h06, 8'h10);
    $display("test flags done");
    for (int i = 0; i < 3; i++) begin
      wm = 1;
      wa = 1;
      idle(4);
      pulse(ev[i]);
      idle(3);
      rd(8'h05, {3'h4, ev[i][2], 1'b0, ev[i][4], 1'b0, ev[i][3]});
      acc(1'b1, 8'h05, 8'h15);
      idle(1);
      cmp("fault pin", 8'h00, {7'h0, pin});
      cmp("int_n", 8'h01, {7'h0, int_n});
      if (ev[i] == 5'h04) wm = 0;
      else wa = 0;
      idle(6);
      cmp("fault pin", 8'h00, {7'h0, pin});
      wm = 0;
      wa = 0;
      idle(6);
      cmp("fault pin", 8'h01, {7'h0, pin});
    end
    wm = 1;
    frc_n = 0;
    idle(4);
    pulse(5'h10);
    idle(3);
    cmp("fault pin", 8'h01, {7'h0, pin});
    rd(8'h05, 8'h84);
    frc_n = 1;
    idle(4);
    cmp("fault pin", 8'h00, {7'h0, pin});
    wm = 0;
    spc = 1;
    idle(6);
    pulse(5'h14);
    idle(3);
    cmp("fault pin", 8'h01, {7'h0, pin});
    rd(8'h05, 8'h00);
    $display("test fault pin done");
    report_and_stop();
  end
endmodule
